// File: rtl/clk_synth_pkg.sv
// Purpose: shared constants, codes and decoders of the clock control block
// Assumes: register bus is 32-bit classic Wishbone, byte addressed
// Notes: divider codes decode to plain integer divide ratios
package clk_synth_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLIP = 8'h04;
  localparam logic [7:0] OFS_SWING = 8'h08;
  localparam logic [7:0] OFS_MARGIN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int CODE_W = 2;
  localparam int CTRL_P_LSB = 0;
  localparam int CTRL_N_LSB = 2; // bank m code at 2 + 2*m
  localparam int N_BANKS = 3;
  localparam int N_SINGLE = 10; // a3 a4 b0..b3 c0..c3
  localparam int N_DIFF = 3;
  localparam int DIV_W = 7;
  localparam int FRAC_W = 9;
  localparam int MARGIN_INT_LSB = 16;
  localparam int N_EVENTS = 2;
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int ST_LOCK = 0;
  localparam int ST_REFSRC = 1;
  localparam int ST_BYPASS = 2;
  localparam int ST_MARGIN = 3;

  // ****************************************************************
  // reset values and fixed ratios
  // ****************************************************************
  localparam logic [1:0] P_CODE_RST = 2'h3;
  localparam logic [1:0] N_CODE_RST = 2'h0;
  localparam logic [6:0] FB_DIV_FIXED = 7'h64; // integer 100
  localparam logic [8:0] FB_FRAC_FIXED = 9'h000;
  localparam logic [3:0] SWITCH_QUIET = 4'h8; // cycles muted on a switch

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  // input predivider: 00 /1, 01 /2, 10 /4, 11 /8
  function automatic logic [DIV_W-1:0] pre_div_of(input logic [1:0] c);
    pre_div_of = 7'h01 << c;
  endfunction

  // bank output divider: 00 /16, 01 /20, 10 /25, 11 /100
  function automatic logic [DIV_W-1:0] out_div_of(input logic [1:0] c);
    unique case (c)
      2'h0: out_div_of = 7'h10;
      2'h1: out_div_of = 7'h14;
      2'h2: out_div_of = 7'h19;
      default: out_div_of = 7'h64;
    endcase
  endfunction

endpackage

// File: rtl/div_if.sv
// Purpose: carrier between the control core and one clock divider
// Assumes: single clock domain
// Notes: source is a sampled clock level, out is the divided level
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic src;
  logic [clk_synth_pkg::DIV_W-1:0] divisor;
  logic mute;
  logic out;
  modport core (output src, output divisor, output mute, input out);
  modport div (input src, input divisor, input mute, output out);
endinterface
`default_nettype wire

// File: rtl/level_sync.sv
// Purpose: two-flop synchroniser for asynchronous control levels
// Assumes: inputs are slow static levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // two stages; resets to zero, matching the pin defaults
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // level_sync
`default_nettype wire

// File: rtl/edge_divider.sv
// Purpose: integer divider of a sampled clock level
// Assumes: source toggles slower than half of core_clk
// Notes: divide by one passes the level straight through
`timescale 1ns/1ps
`default_nettype none
module edge_divider (
  input wire logic core_clk,
  input wire logic resetn,
  div_if.div port
);
  logic prev_q;
  logic [clk_synth_pkg::DIV_W-1:0] cnt_q;
  logic rise;

  assign rise = port.src & ~prev_q;

  // count source rising edges, wrap at the divisor
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_q <= 1'b0;
      cnt_q <= '0;
    end
    else if (port.mute)
    begin
      prev_q <= 1'b0; // restart phase cleanly after a switch
      cnt_q <= '0;
    end
    else
    begin
      prev_q <= port.src;
      if (rise)
        cnt_q <= (cnt_q + 7'h01 >= port.divisor) ? '0 : cnt_q + 7'h01;
    end
  end

  // high for the first half of each period
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      port.out <= 1'b0;
    else if (port.mute)
      port.out <= 1'b0;
    else if (port.divisor == 7'h01)
      port.out <= port.src;
    else
      port.out <= (cnt_q < (port.divisor >> 1));
  end
endmodule // edge_divider
`default_nettype wire

// File: rtl/clock_synth_config_control.sv
// Purpose: control core of a pll clock generator: reference and bypass
//          selection, divider decoding, margining, lock, output phase
// Assumes: reference and pll levels are sampled on core_clk; pins
//          ref/bypass/test/lock are asynchronous
// Notes: registers on classic Wishbone; one level interrupt output
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module clock_synth_config_control (
  input wire logic core_clk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [clk_synth_pkg::ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatWr,
  output logic [31:0] wbDatRd,
  output logic wbAck,
  output logic irq,
  // static control pins
  input wire logic refSourceSelect,
  input wire logic bypassSelect,
  input wire logic marginSelect,
  // reference and pll levels
  input wire logic diffReferencePair,
  input wire logic singleEndedReference,
  input wire logic pllVcoLevel,
  input wire logic pllLockRaw,
  // towards the pll
  output logic pllRefLevel,
  output logic [clk_synth_pkg::DIV_W-1:0] fbDivInt,
  output logic [clk_synth_pkg::FRAC_W-1:0] fbDivFrac,
  output logic lockOut,
  // output banks
  output logic [2:0] bankAOutputs,
  output logic [2:0] bankAOutputsN,
  output logic [2:0] outputSwingSelect,
  output logic [1:0] bankASingle,
  output logic [3:0] bankBOutputs,
  output logic [3:0] bankCOutputs
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int NB = clk_synth_pkg::N_BANKS;
  localparam int NE = clk_synth_pkg::N_EVENTS;
  localparam int NS = clk_synth_pkg::N_SINGLE;

  logic [3:0] pinSync;
  logic refSelS;
  logic bypassS;
  logic marginS;
  logic lockS;
  logic [1:0] pCode_q;
  logic [2*NB-1:0] nCode_q;
  logic [NS-1:0] phaseFlipBit_q;
  logic [2:0] swing_q;
  logic [clk_synth_pkg::DIV_W-1:0] marginInt_q;
  logic [clk_synth_pkg::FRAC_W-1:0] marginFrac_q;
  logic [NE-1:0] irqStat_q;
  logic [NE-1:0] irqStat_d;
  logic [NE-1:0] irqMask_q;
  logic [NE-1:0] events;
  logic lockPrev_q;
  logic routePrev_q;
  logic [3:0] quiet_q;
  logic mute;
  logic selRef;
  logic bankSrc;
  logic [NB-1:0] bankClk;
  logic [NS-1:0] seClk;
  logic [NS-1:0] seOut_q;
  clk_synth_pkg::bus_state_t busState_q;
  logic busReq;
  logic wrEn;
  logic [31:0] byteMask;
  logic [31:0] wrVal;
  logic [31:0] rdMux;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // pins are asynchronous; settle them before any selection uses them
  level_sync #(
    .W(4)
  ) u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .din({pllLockRaw, marginSelect, bypassSelect, refSourceSelect}),
    .dout(pinSync)
  );

  assign refSelS = pinSync[0];
  assign bypassS = pinSync[1];
  assign marginS = pinSync[2];
  assign lockS = pinSync[3];

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // one ack per request, ack dropped in the following cycle
  assign busReq = wbCyc & wbStb;
  assign wrEn = busReq & wbWe &
    (busState_q == clk_synth_pkg::BUS_IDLE);
  assign wbAck = (busState_q == clk_synth_pkg::BUS_ACK);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      busState_q <= clk_synth_pkg::BUS_IDLE;
    else
    begin
      unique case (busState_q)
        clk_synth_pkg::BUS_IDLE:
          if (busReq)
            busState_q <= clk_synth_pkg::BUS_ACK;
        clk_synth_pkg::BUS_ACK:
          busState_q <= clk_synth_pkg::BUS_IDLE;
        default:
          busState_q <= clk_synth_pkg::BUS_IDLE;
      endcase
    end
  end

  // byte lanes gate each byte of a write
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      byteMask[8*b +: 8] = {8{wbSel[b]}};
  end

  // write value: the addressed register with only the selected bytes
  // replaced; read back mux already holds the old value in place
  assign wrVal = (rdMux & ~byteMask) | (wbDatWr & byteMask);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // divider codes; predivider powers up as divide by eight
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pCode_q <= clk_synth_pkg::P_CODE_RST;
      nCode_q <= {NB{clk_synth_pkg::N_CODE_RST}};
    end
    else if (wrEn && wbAdr == clk_synth_pkg::OFS_CTRL)
    begin
      pCode_q <= wrVal[clk_synth_pkg::CTRL_P_LSB +: 2];
      nCode_q <= wrVal[clk_synth_pkg::CTRL_N_LSB +: 2*NB];
    end
  end

  // per single-ended output phase flip and differential swing bits, all default 0
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phaseFlipBit_q <= '0;
      swing_q <= '0;
    end
    else if (wrEn && wbAdr == clk_synth_pkg::OFS_FLIP)
      phaseFlipBit_q <= wrVal[NS-1:0];
    else if (wrEn && wbAdr == clk_synth_pkg::OFS_SWING)
      swing_q <= wrVal[2:0];
  end

  // margining divider; resets to the unmargined ratio
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      marginInt_q <= clk_synth_pkg::FB_DIV_FIXED;
      marginFrac_q <= clk_synth_pkg::FB_FRAC_FIXED;
    end
    else if (wrEn && wbAdr == clk_synth_pkg::OFS_MARGIN)
    begin
      marginInt_q <= wrVal[clk_synth_pkg::MARGIN_INT_LSB +: 7];
      marginFrac_q <= wrVal[clk_synth_pkg::FRAC_W-1:0];
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // lock gained and lost are the events software cares about
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lockPrev_q <= 1'b0;
    else
      lockPrev_q <= lockS;
  end

  assign events[clk_synth_pkg::EV_LOCK_GAIN] = lockS & ~lockPrev_q;
  assign events[clk_synth_pkg::EV_LOCK_LOSS] = ~lockS & lockPrev_q;

  // write one clears; a new event in the same cycle wins
  always_comb
  begin
    irqStat_d = irqStat_q;
    if (wrEn && wbAdr == clk_synth_pkg::OFS_IRQ_STAT && wbSel[0])
      irqStat_d = irqStat_q & ~wbDatWr[NE-1:0];
    irqStat_d = irqStat_d | events;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irqStat_q <= '0;
    else
      irqStat_q <= irqStat_d;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irqMask_q <= '0;
    else if (wrEn && wbAdr == clk_synth_pkg::OFS_IRQ_MASK && wbSel[0])
      irqMask_q <= wbDatWr[NE-1:0];
  end

  assign irq = |(irqStat_q & irqMask_q);

  // ****************************************************************
  // read back
  // ****************************************************************
  // unmapped offsets answer with zero
  always_comb
  begin
    rdMux = 32'h00000000;
    unique case (wbAdr)
      clk_synth_pkg::OFS_CTRL:
        rdMux[2*NB+1:0] = {nCode_q, pCode_q};
      clk_synth_pkg::OFS_FLIP:
        rdMux[NS-1:0] = phaseFlipBit_q;
      clk_synth_pkg::OFS_SWING:
        rdMux[2:0] = swing_q;
      clk_synth_pkg::OFS_MARGIN:
        rdMux = {9'h000, marginInt_q, 7'h00, marginFrac_q};
      clk_synth_pkg::OFS_STATUS:
        rdMux[3:0] = {marginS, bypassS, refSelS, lockS};
      clk_synth_pkg::OFS_IRQ_STAT:
        rdMux[NE-1:0] = irqStat_q;
      clk_synth_pkg::OFS_IRQ_MASK:
        rdMux[NE-1:0] = irqMask_q;
      default:
        rdMux = 32'h00000000;
    endcase
  end

  // read data is captured with the request, valid while ack is high
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      wbDatRd <= 32'h00000000;
    else if (busReq && busState_q == clk_synth_pkg::BUS_IDLE)
      wbDatRd <= rdMux;
  end

  // ****************************************************************
  // reference and feedback selection
  // ****************************************************************
  // unused reference input is simply not looked at
  assign selRef = refSelS ? singleEndedReference : diffReferencePair;

  // feedback ratio: fixed 100, or the programmed margin value
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fbDivInt <= clk_synth_pkg::FB_DIV_FIXED;
      fbDivFrac <= clk_synth_pkg::FB_FRAC_FIXED;
    end
    else if (marginS)
    begin
      fbDivInt <= marginInt_q;
      fbDivFrac <= marginFrac_q;
    end
    else
    begin
      fbDivInt <= clk_synth_pkg::FB_DIV_FIXED;
      fbDivFrac <= clk_synth_pkg::FB_FRAC_FIXED;
    end
  end

  // lock follows the settled detector level
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lockOut <= 1'b0;
    else
      lockOut <= lockS;
  end

  // ****************************************************************
  // glitch guard on source switching
  // ****************************************************************
  // a change of refSourceSelect or bypassSelect alone mutes the dividers briefly so no runt pulse escapes;
  // costs 8 cycles of silence; both changing in the same cycle cancel and do not mute
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      routePrev_q <= 1'b0;
      quiet_q <= '0;
    end
    else
    begin
      routePrev_q <= refSelS ^ bypassS;
      if ((refSelS ^ bypassS) != routePrev_q)
        quiet_q <= clk_synth_pkg::SWITCH_QUIET;
      else if (quiet_q != 4'h0)
        quiet_q <= quiet_q - 4'h1;
    end
  end

  assign mute = (quiet_q != 4'h0);

  // ****************************************************************
  // dividers
  // ****************************************************************
  div_if preIf ();
  div_if bankIf [NB] ();

  assign preIf.src = selRef;
  assign preIf.divisor = clk_synth_pkg::pre_div_of(pCode_q);
  assign preIf.mute = mute;

  edge_divider u_prediv (
    .core_clk(core_clk),
    .resetn(resetn),
    .port(preIf)
  );

  // divided reference goes to the phase detector
  assign pllRefLevel = preIf.out;

  // bypass feeds the reference straight to the bank dividers
  assign bankSrc = bypassS ? selRef : pllVcoLevel;

  genvar g;
  generate
    for (g = 0; g < NB; g++)
    begin : g_bank
      assign bankIf[g].src = bankSrc;
      assign bankIf[g].divisor =
        clk_synth_pkg::out_div_of(nCode_q[2*g +: 2]);
      assign bankIf[g].mute = mute;
      assign bankClk[g] = bankIf[g].out;
      edge_divider u_bankdiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .port(bankIf[g])
      );
    end
  endgenerate

  // ****************************************************************
  // output stage
  // ****************************************************************
  // single-ended order: a3 a4 b0 b1 b2 b3 c0 c1 c2 c3
  assign seClk = {{4{bankClk[2]}}, {4{bankClk[1]}}, {2{bankClk[0]}}};

  // flip per output; flipping the odd one of a pair makes it complementary
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      seOut_q <= '0;
    else
      seOut_q <= seClk ^ phaseFlipBit_q;
  end

  assign bankASingle = seOut_q[1:0];
  assign bankBOutputs = seOut_q[5:2];
  assign bankCOutputs = seOut_q[9:6];

  // differential bank a: true and complement from one flop each
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bankAOutputs <= '0;
      bankAOutputsN <= '1;
    end
    else
    begin
      bankAOutputs <= {3{bankClk[0]}};
      bankAOutputsN <= {3{~bankClk[0]}};
    end
  end

  assign outputSwingSelect = swing_q;

endmodule // clock_synth_config_control
`default_nettype wire

// File: bench/ref_pll_model.sv
// Purpose: reference sources and pll stand-in for the clock control block
// Assumes: levels are sampled by the block on core_clk
// Notes: reference and vco toggles land on falling core_clk edges, away from sampling
`timescale 1ns/1ps
`default_nettype none
module ref_pll_model (
  input wire logic lockReq,
  output logic diffReferencePair,
  output logic singleEndedReference,
  output logic pllVcoLevel,
  output logic pllLockRaw
);
  // periods of 8, 6 and 4 core cycles keep the three sources apart
  initial
  begin
    diffReferencePair = 1'b0;
    singleEndedReference = 1'b0;
    pllVcoLevel = 1'b0;
    pllLockRaw = 1'b0;
  end
  always #20 diffReferencePair = ~diffReferencePair;
  always #15 singleEndedReference = ~singleEndedReference;
  always #10 pllVcoLevel = ~pllVcoLevel;
  // lock detector answers after an analog delay, unrelated to core_clk
  always @(lockReq) pllLockRaw <= #7 lockReq;
endmodule // ref_pll_model
`default_nettype wire

// File: bench/clock_synth_config_control_sva.sv
// Purpose: port-level checks of the clock control block
// Assumes: one core_clk domain, resetn asynchronous active low
// Notes: pin checks wait five samples to cover the two-flop sync
`timescale 1ns/1ps
`default_nettype none
module clock_synth_config_control_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic [31:0] wbDatRd,
  input wire logic wbAck,
  input wire logic refSourceSelect,
  input wire logic marginSelect,
  input wire logic pllLockRaw,
  input wire logic [clk_synth_pkg::DIV_W-1:0] fbDivInt,
  input wire logic [clk_synth_pkg::FRAC_W-1:0] fbDivFrac,
  input wire logic lockOut,
  input wire logic [2:0] bankAOutputs,
  input wire logic [2:0] bankAOutputsN,
  input wire logic [3:0] bankBOutputs
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic req;
  assign req = wbCyc & wbStb;
  // bus answers exactly one cycle after an idle request
  a_ack_next: assert property (req && !wbAck |=> wbAck)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  a_rd_hold: assert property (!req |=> $stable(wbDatRd))
    else $error("read data moved without a request");
  // a settled test pin low pins the feedback ratio at 100
  a_fb_fixed: assert property (!marginSelect [*5] |->
    fbDivInt == 7'h64 && fbDivFrac == 9'h000)
    else $error("feedback ratio not fixed in normal mode");
  a_lock_high: assert property (pllLockRaw [*5] |-> lockOut)
    else $error("lock output low while pll locked");
  a_lock_low: assert property (!pllLockRaw [*5] |-> !lockOut)
    else $error("lock output high while pll unlocked");
  a_diff_pair: assert property (bankAOutputsN == ~bankAOutputs)
    else $error("bank a complement not inverse of true side");
  // a reference select change must quiet banks a and b before they restart
  a_route_mute: assert property ($changed(refSourceSelect) |->
    ##[2:8] (bankBOutputs == 4'h0 && bankAOutputs == 3'h0))
    else $error("route change did not mute the banks");
  c_bus: cover property (req ##1 wbAck);
  c_lock: cover property ($rose(lockOut));
  c_margin: cover property (marginSelect [*5]);
endmodule // clock_synth_config_control_sva
bind clock_synth_config_control clock_synth_config_control_sva chk (.*);
`default_nettype wire

// File: bench/clock_synth_config_control_bench.sv
// Purpose: directed regression of the clock control block
// Assumes: partner model supplies reference, vco and lock levels
// Notes: divider ratios are checked by timing output periods
`timescale 1ns/1ps
`default_nettype none
module clock_synth_config_control_bench;
  logic core_clk, resetn, wbCyc, wbStb, wbWe, wbAck, irq, lockReq, probe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel, bankBOutputs, bankCOutputs;
  logic [31:0] wbDatWr, wbDatRd, rd;
  logic refSourceSelect, bypassSelect, marginSelect, lockOut, pllRefLevel;
  logic diffReferencePair, singleEndedReference, pllVcoLevel, pllLockRaw;
  logic [6:0] fbDivInt;
  logic [8:0] fbDivFrac;
  logic [2:0] bankAOutputs, bankAOutputsN, outputSwingSelect;
  logic [1:0] bankASingle;
  logic [9:0] flipVal[4] = '{10'h000, 10'h2AA, 10'h155, 10'h3FF};
  int nDiv[4] = '{16, 20, 25, 100};
  int n_fail = 0, checks_done = 0, sel = 0, per;

  clock_synth_config_control dut (.*);
  ref_pll_model partner (.*);

  // output whose period is timed
  always_comb
    case (sel)
      0: probe = pllRefLevel;
      default: probe = bankBOutputs[0];
    endcase

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatWr} <= {2'h3, we, a, 4'hF, d};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 40);
    rd = wbDatRd;
    if (n >= 40)
      n_fail++;
    {wbCyc, wbStb} <= 2'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // skip two rising edges, then count cycles to the next one
  task automatic period(input int s, output int p);
    int e;
    logic last;
    sel = s;
    e = 0;
    p = 0;
    last = 1'b1;
    while (e < 3)
    begin
      @(posedge core_clk);
      if (e == 2)
        p++;
      if (probe && !last)
        e++;
      last = probe;
    end
  endtask

  initial
  begin
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatWr} = '0;
    {refSourceSelect, bypassSelect, marginSelect, lockReq, resetn} = '0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    // ****************************************************************
    // reset values, read-only and unmapped places
    // ****************************************************************
    rdchk(8'h00, 32'h0000_0003);
    rdchk(8'h0C, 32'h0064_0000);
    wb(1'b1, 8'h10, 32'h0000_000F);
    rdchk(8'h10, 32'h0);
    rdchk(8'h1C, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h08, 32'(i));
      chk(32'(outputSwingSelect), 32'(i));
    end
    $display("test registers done");
    // ****************************************************************
    // predivider on both reference routes, then bank dividers
    // ****************************************************************
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, 8'h00, 32'(c));
      period(0, per);
      chk(32'(per), 32'(8 << c));
    end
    refSourceSelect <= 1'b1;
    repeat (16) @(posedge core_clk); // let the switch mute run out
    wb(1'b1, 8'h00, 32'h0);
    period(0, per);
    chk(32'(per), 32'h6);
    for (int b = 0; b < 2; b++)
    begin
      bypassSelect <= b[0];
      repeat (16) @(posedge core_clk); // let the switch mute run out
      for (int c = 0; c < 4; c++)
      begin
        wb(1'b1, 8'h00, 32'((c << 4) | 3));
        period(1, per);
        chk(32'(per), 32'(nDiv[c] * (b ? 6 : 4)));
      end
    end
    $display("test dividers done");
    // ****************************************************************
    // phase flip pairs
    // ****************************************************************
    for (int f = 0; f < 4; f++)
    begin
      wb(1'b1, 8'h04, 32'(flipVal[f]));
      repeat (4)
      begin
        repeat (7) @(posedge core_clk);
        // banks a and c share code and source, so the true side is the base
        chk({bankASingle, bankCOutputs}, {6{bankAOutputs[0]}} ^
          {flipVal[f][1:0], flipVal[f][9:6]});
        chk({bankASingle, bankBOutputs, bankCOutputs},
          {bankASingle[0] ^ f[0] ^ f[1], bankASingle[0],
           bankBOutputs[2] ^ f[0] ^ f[1], bankBOutputs[2],
           bankBOutputs[0] ^ f[0] ^ f[1], bankBOutputs[0],
           bankCOutputs[2] ^ f[0] ^ f[1], bankCOutputs[2],
           bankCOutputs[0] ^ f[0] ^ f[1], bankCOutputs[0]});
      end
    end
    $display("test flip done");
    // ****************************************************************
    // margining, lock and interrupt
    // ****************************************************************
    wb(1'b1, 8'h0C, 32'h0063_01E6);
    marginSelect <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({fbDivInt, fbDivFrac}, {7'h63, 9'h1E6});
    rdchk(8'h10, 32'h0000_000E);
    marginSelect <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({fbDivInt, fbDivFrac}, {7'h64, 9'h000});
    lockReq <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(lockOut, 1'b1);
    rdchk(8'h14, 32'h1);
    chk(irq, 1'b0);
    wb(1'b1, 8'h18, 32'h3);
    @(posedge core_clk);
    chk(irq, 1'b1);
    wb(1'b1, 8'h14, 32'h1);
    @(posedge core_clk);
    chk(irq, 1'b0);
    lockReq <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk({lockOut, irq}, 2'h1);
    rdchk(8'h14, 32'h2);
    $display("test lock done");
    wrap_up();
  end

  // longest run is about 5500 cycles; cut a hang well beyond that
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule // clock_synth_config_control_bench
`default_nettype wire
